// >>> hw/eio_pkg.sv
// Purpose: Shared constants for the encoder I/O strobe and timer block
// Assumes: 50 MHz ref_clk, 16-bit status and command words
// Notes:   Word addresses on the register port, one 16-bit word per address
//
// What this block does
// RULE1: Exchange holds 32 status bits, 15 status words, 32 command bits, 6 command words.
// RULE2: Timer 1 result appears in status word eleven.
// RULE3: Single-input timer 1 measures ms from configured edge to opposite edge of input 10.
// RULE4: Two-input timer 1 measures ms from input 10 configured edge to input 9's.
// RULE5: Timer 2 result appears in status word twelve.
// RULE6: Single-input timer 2 measures ms from configured edge to opposite edge of input 12.
// RULE7: Two-input timer 2 measures ms from input 12 configured edge to input 11's.
// RULE8: Counts per timebase go in status word two; timebase defaults to 1000 ms.
// RULE9: Strobes on inputs 9 to 12 fire on their own rising or falling edge.
// RULE10: Each strobe is always enabled or gated by comparator output 5 to 8.
// RULE11: Points 9 to 12 are inputs unless their output option makes them outputs 5 to 8.
// RULE12: Continue policy keeps outputs following the counts when host is off.
// RULE13: Force-off policy drives all outputs off when host is off.
// RULE14: Hold policy freezes all outputs when host is off.
// RULE15: Strobe register updates within 1 ms; strobes arrive at least 2 ms apart.
// RULE16: Strobe latch bits sit at discrete status bits 20 to 23.
// RULE17: A gated-off strobe ignores edges and leaves register and latch alone.
// RULE18: Timers use a free-running 1 ms tick; the timebase window restarts after each report.
package eio_pkg;

	// Exchange sizes [RULE1]
	localparam int STAT_BITS  = 32;
	localparam int STAT_WORDS = 15;
	localparam int CMD_BITS   = 32;
	localparam int CMD_WORDS  = 6;
	localparam int WORD_W     = 16;
	localparam int ADDR_W     = 6;

	// Register word addresses
	localparam logic [ADDR_W-1:0] A_CFG        = 6'h00;
	localparam logic [ADDR_W-1:0] A_TIMEBASE   = 6'h01;
	localparam logic [ADDR_W-1:0] A_HOST       = 6'h02;
	localparam logic [ADDR_W-1:0] A_IRQ_STAT   = 6'h03;
	localparam logic [ADDR_W-1:0] A_IRQ_MASK   = 6'h04;
	localparam logic [ADDR_W-1:0] A_DSTAT_LO   = 6'h05;
	localparam logic [ADDR_W-1:0] A_DSTAT_HI   = 6'h06;
	localparam logic [ADDR_W-1:0] A_DCMD_LO    = 6'h07;
	localparam logic [ADDR_W-1:0] A_DCMD_HI    = 6'h08;
	localparam logic [ADDR_W-1:0] A_SWORD_BASE = 6'h10;
	localparam logic [ADDR_W-1:0] A_CWORD_BASE = 6'h20;

	// Config register fields
	localparam int CFG_T1_TWO    = 0;
	localparam int CFG_T2_TWO    = 1;
	localparam int CFG_EDGE_LSB  = 2;
	localparam int CFG_GATE_LSB  = 6;
	localparam int CFG_OUTEN_LSB = 10;
	localparam int CFG_POL_LSB   = 14;
	localparam int HOST_OUT_EN   = 0;
	localparam int HOST_PRESENT  = 1;

	// Reset values
	localparam logic [WORD_W-1:0] CFG_RESET      = 16'h0000;
	localparam logic [WORD_W-1:0] TIMEBASE_RESET = 16'h03E8;
	localparam logic [WORD_W-1:0] HOST_RESET     = 16'h0000;

	// Status word indexes and discrete bit positions
	localparam int SW_POSITION   = 0;
	localparam int SW_CPT        = 1;
	localparam int SW_STROBE_LSB = 3;
	localparam int SW_TIMER1     = 10;
	localparam int SW_TIMER2     = 11;
	localparam int DS_INPUT_LSB  = 16;
	localparam int DS_LATCH_LSB  = 20;

	// Interrupt status bits
	localparam int IRQ_STROBE_LSB = 0;
	localparam int IRQ_T1         = 4;
	localparam int IRQ_T2         = 5;
	localparam int IRQ_CPT        = 6;
	localparam int IRQ_W          = 7;

	// Timing
	localparam int CLK_NS            = 20;
	localparam int MS_NS             = 1000000;
	localparam int MS_CYCLES_DEF     = MS_NS / CLK_NS;
	localparam int STROBE_UPDATE_NS  = 1000000;
	localparam int STROBE_SPACING_NS = 2000000;

	// Output policy when the host is away
	typedef enum logic [1:0]
	{
		POL_CONTINUE  = 2'h0,
		POL_FORCE_OFF = 2'h1,
		POL_HOLD      = 2'h2
	} eio_policy_t;

	// Saturating increment, shared by timers and rate counter
	function automatic logic [WORD_W-1:0] eio_sat_inc(logic [WORD_W-1:0] v, logic inc);
		if (inc && v != 16'hFFFF)
			return v + 16'h0001;
		return v;
	endfunction : eio_sat_inc

endpackage : eio_pkg

// >>> hw/eio_sync.sv
// Purpose: Two-flop synchroniser for field pins
// Assumes: Inputs are asynchronous levels
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
module eio_sync #(
	parameter int W = 4
) (
	// Clock and reset
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	// Data
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_q
);
	logic [W-1:0] meta_q;

	if (W < 1)
	begin : g_bad_w
		$error("eio_sync width must be at least 1");
	end

	// Two stages, reset to zero
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end
endmodule : eio_sync

// >>> hw/eio_interval_timer.sv
// Purpose: Millisecond interval timer between a start and a stop event
// Assumes: tick_ms is a one-cycle pulse every millisecond
// Notes:   A new start while running restarts the count; stop wins a tie
`timescale 1ns/100ps
module eio_interval_timer
	import eio_pkg::*;
(
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	// Events
	input  wire logic              tick_ms,
	input  wire logic              start_evt,
	input  wire logic              stop_evt,
	// Result
	output logic [WORD_W-1:0]      result_q,
	output logic                   done_q
);
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b01,
		ST_RUN  = 2'b10
	} eio_tmr_state_t;

	eio_tmr_state_t    state_q;
	logic [WORD_W-1:0] count_q;

	// Start, count on ticks, stop and report [RULE3] [RULE4] [RULE6] [RULE7] [RULE18]
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			state_q  <= ST_IDLE;
			count_q  <= '0;
			result_q <= '0;
			done_q   <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			case (state_q)
				ST_IDLE:
				begin
					if (start_evt)
					begin
						count_q <= '0;
						state_q <= ST_RUN;
					end
				end
				ST_RUN:
				begin
					if (stop_evt)
					begin
						result_q <= eio_sat_inc(count_q, tick_ms);
						done_q   <= 1'b1;
						state_q  <= ST_IDLE;
					end
					else if (start_evt)
						count_q <= '0;
					else
						count_q <= eio_sat_inc(count_q, tick_ms);
				end
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	a_stop_reports: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE3]
		(state_q == ST_RUN && stop_evt && !tick_ms) |=> (done_q && result_q == $past(count_q)))
		else $error("timer result does not match elapsed count");

	a_idle_no_done: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE4]
		(state_q == ST_IDLE) |=> !done_q)
		else $error("timer reported without running");
endmodule : eio_interval_timer

// >>> hw/eio_strobe_timer.sv
// Purpose: Strobes, interval timers, rate measurement and output policy
// Assumes: count_value, count_pulse and rcmp_on come from logic on ref_clk
// Notes:   Points 9..12 are two-way pins split into in, out and enable
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/100ps
module eio_strobe_timer #(
	parameter int MS_CYCLES = eio_pkg::MS_CYCLES_DEF
) (
	// Clock and reset
	input  wire logic                         ref_clk,
	input  wire logic                         rst_n,
	// Register port
	input  wire logic [eio_pkg::ADDR_W-1:0]   reg_addr,
	input  wire logic [eio_pkg::WORD_W-1:0]   reg_wdata,
	input  wire logic                         reg_wr,
	input  wire logic                         reg_rd,
	output logic      [eio_pkg::WORD_W-1:0]   reg_rdata,
	output logic                              irq,
	// Counter side
	input  wire logic [eio_pkg::WORD_W-1:0]   count_value,
	input  wire logic                         count_pulse,
	input  wire logic [7:0]                   rcmp_on,
	// Field points 9..12 and outputs 1..4
	input  wire logic [3:0]                   point_in,
	output logic      [3:0]                   point_out,
	output logic      [3:0]                   point_oe,
	output logic      [3:0]                   out_main
);
	import eio_pkg::*;

	if (MS_CYCLES < 1)
	begin : g_bad_ms
		$error("MS_CYCLES must be at least 1");
	end

	logic [WORD_W-1:0] cfg_q;
	logic [WORD_W-1:0] timebase_q;
	logic [WORD_W-1:0] host_q;
	logic [IRQ_W-1:0]  irq_stat_q;
	logic [IRQ_W-1:0]  irq_stat_d;
	logic [IRQ_W-1:0]  irq_mask_q;
	logic [IRQ_W-1:0]  irq_event;
	logic [CMD_BITS-1:0] dcmd_q;
	logic [WORD_W-1:0] cword_q [CMD_WORDS];
	logic [3:0]        pin_s;
	logic [3:0]        pin_prev_q;
	logic [3:0]        rise;
	logic [3:0]        fall;
	logic [3:0]        trig;
	logic [3:0]        opp;
	logic [3:0]        is_input;
	logic [3:0]        gate_ok;
	logic [3:0]        strobe_hit;
	logic [3:0]        latch_q;
	logic [3:0]        latch_clr;
	logic [WORD_W-1:0] strobe_q [4];
	logic [31:0]       ms_cnt_q;
	logic              tick_q;
	logic [WORD_W-1:0] tb_ms_q;
	logic [WORD_W-1:0] tb_last;
	logic              tb_end;
	logic [WORD_W-1:0] cpt_acc_q;
	logic [WORD_W-1:0] cpt_q;
	logic              cpt_rep_q;
	logic [WORD_W-1:0] t1_res;
	logic [WORD_W-1:0] t2_res;
	logic              t1_done;
	logic              t2_done;
	logic              t1_stop;
	logic              t2_stop;
	logic [7:0]        out_q;
	logic              host_ok;
	eio_policy_t       policy;
	logic [CMD_BITS-1:0] dstat;
	logic [WORD_W-1:0] rd_d;

	// Config field views
	assign policy   = eio_policy_t'(cfg_q[CFG_POL_LSB +: 2]);
	assign is_input = ~cfg_q[CFG_OUTEN_LSB +: 4]; // [RULE11]
	assign host_ok  = host_q[HOST_OUT_EN] & host_q[HOST_PRESENT];

	// Pins pass two flops before any logic
	eio_sync #(.W(4)) u_pin_sync (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.async_in (point_in),
		.sync_q   (pin_s)
	);

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			pin_prev_q <= '0;
		else
			pin_prev_q <= pin_s;
	end

	// Edge selection and comparator gating per strobe
	always_comb
	begin
		rise = pin_s & ~pin_prev_q;
		fall = ~pin_s & pin_prev_q;
		for (int i = 0; i < 4; i++)
		begin
			trig[i]    = cfg_q[CFG_EDGE_LSB + i] ? fall[i] : rise[i]; // [RULE9]
			opp[i]     = cfg_q[CFG_EDGE_LSB + i] ? rise[i] : fall[i];
			gate_ok[i] = ~cfg_q[CFG_GATE_LSB + i] | rcmp_on[4 + i]; // [RULE10]
			// Points driven as outputs never strobe
			strobe_hit[i] = trig[i] & gate_ok[i] & is_input[i]; // [RULE17]
		end
	end

	// Strobe capture one cycle after the edge, far inside 1 ms [RULE15]
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < 4; i++)
				strobe_q[i] <= '0;
			latch_q <= '0;
		end
		else
		begin
			for (int i = 0; i < 4; i++)
				if (strobe_hit[i])
					strobe_q[i] <= count_value;
			// Set wins over a host clear in the same cycle
			latch_q <= (latch_q & ~latch_clr) | strobe_hit; // [RULE16]
		end
	end

	// Free-running millisecond tick
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			ms_cnt_q <= '0;
			tick_q   <= 1'b0;
		end
		else if (ms_cnt_q == 32'(MS_CYCLES - 1))
		begin
			ms_cnt_q <= '0;
			tick_q   <= 1'b1; // [RULE18]
		end
		else
		begin
			ms_cnt_q <= ms_cnt_q + 32'h00000001;
			tick_q   <= 1'b0;
		end
	end

	// Timer stop sources depend on single or two-input mode
	assign t1_stop = cfg_q[CFG_T1_TWO] ? (trig[0] & is_input[0]) : (opp[1] & is_input[1]); // [RULE3] [RULE4]
	assign t2_stop = cfg_q[CFG_T2_TWO] ? (trig[2] & is_input[2]) : (opp[3] & is_input[3]); // [RULE6] [RULE7]

	eio_interval_timer u_timer1 (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.tick_ms   (tick_q),
		.start_evt (trig[1] & is_input[1]),
		.stop_evt  (t1_stop),
		.result_q  (t1_res),
		.done_q    (t1_done)
	);

	eio_interval_timer u_timer2 (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.tick_ms   (tick_q),
		.start_evt (trig[3] & is_input[3]),
		.stop_evt  (t2_stop),
		.result_q  (t2_res),
		.done_q    (t2_done)
	);

	// A zero timebase would never close; treat it as 1 ms
	assign tb_last = (timebase_q == '0) ? '0 : timebase_q - 16'h0001;
	assign tb_end  = tick_q && (tb_ms_q >= tb_last);

	// Counts per timebase; window restarts at once after each report
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			tb_ms_q   <= '0;
			cpt_acc_q <= '0;
			cpt_q     <= '0;
			cpt_rep_q <= 1'b0;
		end
		else
		begin
			cpt_rep_q <= tb_end;
			if (tb_end)
			begin
				tb_ms_q   <= '0; // [RULE18]
				cpt_q     <= eio_sat_inc(cpt_acc_q, count_pulse); // [RULE8]
				cpt_acc_q <= '0;
			end
			else
			begin
				tb_ms_q   <= eio_sat_inc(tb_ms_q, tick_q);
				cpt_acc_q <= eio_sat_inc(cpt_acc_q, count_pulse);
			end
		end
	end

	// Output policy while the host is away
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			out_q <= '0;
		else if (host_ok)
			out_q <= rcmp_on;
		else
			case (policy)
				POL_CONTINUE:  out_q <= rcmp_on; // [RULE12]
				POL_FORCE_OFF: out_q <= '0; // [RULE13]
				POL_HOLD:      out_q <= out_q; // [RULE14]
				default:       out_q <= rcmp_on;
			endcase
	end

	assign out_main  = out_q[3:0];
	assign point_out = out_q[7:4]; // [RULE11]
	assign point_oe  = cfg_q[CFG_OUTEN_LSB +: 4];

	// Register writes
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			cfg_q      <= CFG_RESET;
			timebase_q <= TIMEBASE_RESET;
			host_q     <= HOST_RESET;
			irq_mask_q <= '0;
			dcmd_q     <= '0;
			for (int i = 0; i < CMD_WORDS; i++)
				cword_q[i] <= '0;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				A_CFG:      cfg_q      <= reg_wdata;
				A_TIMEBASE: timebase_q <= reg_wdata;
				A_HOST:     host_q     <= reg_wdata;
				A_IRQ_MASK: irq_mask_q <= reg_wdata[IRQ_W-1:0];
				A_DCMD_LO:  dcmd_q[15:0]  <= reg_wdata;
				A_DCMD_HI:  dcmd_q[31:16] <= reg_wdata;
				default:
				begin
					for (int i = 0; i < CMD_WORDS; i++)
						if (reg_addr == A_CWORD_BASE + ADDR_W'(i))
							cword_q[i] <= reg_wdata; // [RULE1]
				end
			endcase
		end
	end

	// Command bits 20..23 written as one clear the strobe latches
	assign latch_clr = (reg_wr && reg_addr == A_DCMD_HI) ? reg_wdata[DS_LATCH_LSB - 16 +: 4] : 4'h0;

	// Sticky interrupt status, write one to clear, set wins
	assign irq_event  = {cpt_rep_q, t2_done, t1_done, strobe_hit};
	assign irq_stat_d = (irq_stat_q & ~((reg_wr && reg_addr == A_IRQ_STAT) ? reg_wdata[IRQ_W-1:0] : '0))
		| irq_event;

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			irq_stat_q <= '0;
			irq        <= 1'b0;
		end
		else
		begin
			irq_stat_q <= irq_stat_d;
			irq        <= |(irq_stat_d & irq_mask_q);
		end
	end

	// Discrete status image: comparators, inputs, latches [RULE16]
	assign dstat = {8'h00, latch_q, pin_s, 8'h00, rcmp_on};

	// Read mux; unmapped addresses read zero
	always_comb
	begin
		rd_d = '0;
		case (reg_addr)
			A_CFG:      rd_d = cfg_q;
			A_TIMEBASE: rd_d = timebase_q;
			A_HOST:     rd_d = host_q;
			A_IRQ_STAT: rd_d = WORD_W'(irq_stat_q);
			A_IRQ_MASK: rd_d = WORD_W'(irq_mask_q);
			A_DSTAT_LO: rd_d = dstat[15:0];
			A_DSTAT_HI: rd_d = dstat[31:16];
			A_DCMD_LO:  rd_d = dcmd_q[15:0];
			A_DCMD_HI:  rd_d = dcmd_q[31:16];
			A_SWORD_BASE + ADDR_W'(SW_POSITION):       rd_d = count_value;
			A_SWORD_BASE + ADDR_W'(SW_CPT):            rd_d = cpt_q; // [RULE8]
			A_SWORD_BASE + ADDR_W'(SW_STROBE_LSB):     rd_d = strobe_q[0];
			A_SWORD_BASE + ADDR_W'(SW_STROBE_LSB + 1): rd_d = strobe_q[1];
			A_SWORD_BASE + ADDR_W'(SW_STROBE_LSB + 2): rd_d = strobe_q[2];
			A_SWORD_BASE + ADDR_W'(SW_STROBE_LSB + 3): rd_d = strobe_q[3];
			A_SWORD_BASE + ADDR_W'(SW_TIMER1):         rd_d = t1_res; // [RULE2]
			A_SWORD_BASE + ADDR_W'(SW_TIMER2):         rd_d = t2_res; // [RULE5]
			default:
			begin
				for (int i = 0; i < CMD_WORDS; i++)
					if (reg_addr == A_CWORD_BASE + ADDR_W'(i))
						rd_d = cword_q[i];
			end
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			reg_rdata <= '0;
		else
			reg_rdata <= reg_rd ? rd_d : '0;
	end

	a_strobe_capture: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE15]
		strobe_hit[0] |=> (latch_q[0] && strobe_q[0] == $past(count_value)))
		else $error("strobe 1 not captured next cycle");

	a_edge_select: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE9]
		strobe_hit[3] |-> (cfg_q[CFG_EDGE_LSB + 3] ? (!pin_s[3] && pin_prev_q[3]) : (pin_s[3] && !pin_prev_q[3])))
		else $error("strobe 4 fired on the wrong edge");

	a_gate_blocks: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE10]
		(cfg_q[CFG_GATE_LSB] && !rcmp_on[4]) |-> !strobe_hit[0])
		else $error("strobe 1 fired while its comparator is off");

	a_gate_stable: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE17]
		(trig[0] && cfg_q[CFG_GATE_LSB] && !rcmp_on[4] && !latch_clr[0])
		|=> ($stable(strobe_q[0]) && $stable(latch_q[0])))
		else $error("gated strobe 1 changed its register");

	a_timer1_word: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE2]
		(reg_rd && reg_addr == A_SWORD_BASE + 6'h0A) |=> (reg_rdata == $past(t1_res)))
		else $error("status word eleven is not timer 1");

	a_timer2_word: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE5]
		(reg_rd && reg_addr == A_SWORD_BASE + 6'h0B) |=> (reg_rdata == $past(t2_res)))
		else $error("status word twelve is not timer 2");

	a_cpt_report: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE8]
		tb_end |=> (cpt_rep_q && tb_ms_q == 16'h0000 && cpt_q == eio_sat_inc($past(cpt_acc_q), $past(count_pulse))))
		else $error("timebase report wrong or window not restarted");

	a_force_off: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE13]
		(!host_ok && policy == POL_FORCE_OFF) |=> (out_q == 8'h00))
		else $error("outputs not forced off");

	a_hold_last: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE14]
		(!host_ok && policy == POL_HOLD) |=> $stable(out_q))
		else $error("outputs moved while held");

	a_continue_run: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE12]
		(!host_ok && policy == POL_CONTINUE) |=> (out_q == $past(rcmp_on)))
		else $error("outputs stopped following comparators");

	c_strobe_seen: cover property (@(posedge ref_clk) disable iff (!rst_n) strobe_hit[0]);
	c_timer1_done: cover property (@(posedge ref_clk) disable iff (!rst_n) t1_done);
	c_cpt_report:  cover property (@(posedge ref_clk) disable iff (!rst_n) cpt_rep_q);
	c_hold_state:  cover property (@(posedge ref_clk) disable iff (!rst_n) !host_ok && policy == POL_HOLD);
endmodule : eio_strobe_timer

// >>> verif/eio_field_model.sv
// Purpose: Encoder and field pin side seen by the strobe timer block
// Assumes: Count pulses and comparator levels live on ref_clk
// Notes:   A point set as output reads back what the block drives on it
`timescale 1ns/100ps
module eio_field_model (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// Bench controls
	input  wire logic [7:0]  pulse_gap,
	input  wire logic [3:0]  pin_drive,
	// Block side
	input  wire logic [3:0]  point_out,
	input  wire logic [3:0]  point_oe,
	output logic      [15:0] count_value,
	output logic             count_pulse,
	output logic      [3:0]  point_in
);
	logic [7:0] gap_q;

	// Pulse every pulse_gap cycles; zero parks the encoder so captures are stable
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n || pulse_gap == 8'h00 || gap_q == pulse_gap - 8'h01)
			gap_q <= 8'h00;
		else
			gap_q <= gap_q + 8'h01;
		count_pulse <= rst_n && pulse_gap != 8'h00 && gap_q == pulse_gap - 8'h01;
	end

	// Position follows the pulses one for one
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			count_value <= 16'h0000;
		else if (count_pulse)
			count_value <= count_value + 16'h0001;
	end

	// Wire level: block drive wins where enabled, else the field device
	assign point_in = (point_oe & point_out) | (~point_oe & pin_drive);

endmodule : eio_field_model

// >>> verif/encoder_io_strobe_timer_config_tb_top.sv
// Purpose: Self-checking bench for the strobe, timer and output policy block
// Assumes: 1 ms shortened to 10 clocks through MS_CYCLES
// Notes:   Field pins change 2 ms apart, as real strobe sources must
`timescale 1ns/100ps
module encoder_io_strobe_timer_config_tb_top;
	import eio_pkg::*;
	localparam int MSC = 10;
	logic              ref_clk   = 1'b0;
	logic              rst_n     = 1'b0;
	logic [ADDR_W-1:0] reg_addr  = 6'h00;
	logic [WORD_W-1:0] reg_wdata = 16'h0000;
	logic              reg_wr    = 1'b0;
	logic              reg_rd    = 1'b0;
	logic [7:0]        rcmp_on   = 8'h00;
	logic [7:0]        pulse_gap = 8'h03;
	logic [3:0]        pin_drive = 4'h0;
	logic [WORD_W-1:0] reg_rdata;
	logic [WORD_W-1:0] count_value;
	logic [WORD_W-1:0] cnt;
	logic [WORD_W-1:0] lat;
	logic [3:0]        point_in;
	logic [3:0]        point_out;
	logic [3:0]        point_oe;
	logic [3:0]        out_main;
	logic              irq;
	logic              count_pulse;
	int                fails        = 0;
	int                total_checks = 0;

	always #10 ref_clk = ~ref_clk;

	eio_strobe_timer #(.MS_CYCLES(MSC)) uut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
		.count_value(count_value), .count_pulse(count_pulse), .rcmp_on(rcmp_on), .point_in(point_in),
		.point_out(point_out), .point_oe(point_oe), .out_main(out_main));

	eio_field_model field (.ref_clk(ref_clk), .rst_n(rst_n), .pulse_gap(pulse_gap), .pin_drive(pin_drive),
		.point_out(point_out), .point_oe(point_oe), .count_value(count_value), .count_pulse(count_pulse),
		.point_in(point_in));

	// Compare and count
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc

	// One-cycle write strobe
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe, so sample mid-cycle there
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] exp);
		@(posedge ref_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		check(reg_rdata, exp);
	endtask : rd

	// Field pin change, then the minimum spacing before the next one
	task automatic pin(input int i, input logic v);
		@(posedge ref_clk);
		pin_drive[i] <= v;
		cyc(2 * MSC);
	endtask : pin

	// Start edge on input 10/12, stop on the same pin or on input 9/11
	task automatic tmr(input int t, input logic two, input int ms);
		int a;
		int b;
		a = 2 * t + 1;
		b = two ? 2 * t : a;
		wr(A_CFG, {14'h0000, two & t[0], two & ~t[0]});
		@(posedge ref_clk);
		pin_drive[a] <= 1'b1;
		cyc(ms * MSC);
		pin_drive[b] <= two;
		cyc(2 * MSC);
		rd(A_SWORD_BASE + 6'(SW_TIMER1 + t), 16'(ms));
		pin(a, 1'b0);
		pin(b, 1'b0);
	endtask : tmr

	task automatic wait_irq(input int n);
		int k;
		k = 0;
		while (irq !== 1'b1 && k < n)
		begin
			@(posedge ref_clk);
			k++;
		end
		check(16'(irq), 16'h0001);
	endtask : wait_irq

	task automatic close_out();
		if (fails == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out

	// Watchdog well beyond the thousand or so cycles the sequence needs
	initial
	begin
		cyc(20000);
		fails++;
		close_out();
	end

	initial
	begin
		cyc(12);
		rst_n <= 1'b1;
		// Defaults and exchange sizes
		rd(A_CFG, 16'h0000);
		check(16'(point_oe), 16'h0000);
		rd(A_TIMEBASE, 16'h03E8);
		for (int i = 0; i < CMD_WORDS; i++)
			wr(A_CWORD_BASE + 6'(i), 16'hA500 + 16'(i));
		for (int i = 0; i < CMD_WORDS; i++)
			rd(A_CWORD_BASE + 6'(i), 16'hA500 + 16'(i));
		rd(A_CWORD_BASE + 6'(CMD_WORDS), 16'h0000);
		rd(A_SWORD_BASE + 6'(STAT_WORDS), 16'h0000);
		// Strobes 2 and 4 on falling edges, others rising; encoder parked
		wr(A_TIMEBASE, 16'hFFFF);
		wr(A_IRQ_MASK, 16'h000F);
		wr(A_CFG, 16'h0028);
		pulse_gap <= 8'h00;
		cyc(4);
		cnt = count_value;
		lat = 16'h0000;
		for (int s = 0; s < 4; s++)
		begin
			pin(s, 1'b1);
			rd(A_DSTAT_HI, lat | (s % 2 == 1 ? 16'h0000 : 16'h0010 << s) | 16'h0001 << s);
			pin(s, 1'b0);
			lat = lat | 16'h0010 << s;
			rd(A_DSTAT_HI, lat);
			rd(A_SWORD_BASE + 6'(SW_STROBE_LSB + s), cnt);
		end
		check(16'(irq), 16'h0001);
		rd(A_IRQ_STAT, 16'h000F);
		wr(A_DCMD_HI, 16'h00F0);
		wr(A_IRQ_STAT, 16'h007F);
		rd(A_DSTAT_HI, 16'h0000);
		rd(A_IRQ_STAT, 16'h0000);
		check(16'(irq), 16'h0000);
		// Strobe 1 gated by comparator 5: ignored while off, fires while on
		pulse_gap <= 8'h02;
		cyc(20);
		pulse_gap <= 8'h00;
		cyc(4);
		wr(A_CFG, 16'h0040);
		pin(0, 1'b1);
		pin(0, 1'b0);
		rd(A_DSTAT_HI, 16'h0000);
		rd(A_SWORD_BASE + 6'(SW_STROBE_LSB), cnt);
		cnt = count_value;
		rcmp_on <= 8'h10;
		pin(0, 1'b1);
		rd(A_DSTAT_HI, 16'h0011);
		rd(A_SWORD_BASE + 6'(SW_STROBE_LSB), cnt);
		pin(0, 1'b0);
		rcmp_on <= 8'h00;
		wr(A_DCMD_HI, 16'h00F0);
		// Interval timers in both modes
		tmr(0, 1'b0, 5);
		tmr(0, 1'b1, 3);
		tmr(1, 1'b0, 7);
		tmr(1, 1'b1, 2);
		// Counts per 4 ms window at one pulse per 4 clocks
		pulse_gap <= 8'h04;
		wr(A_TIMEBASE, 16'h0004);
		wr(A_IRQ_STAT, 16'h007F);
		wr(A_IRQ_MASK, 16'h0040);
		wait_irq(200);
		wr(A_IRQ_STAT, 16'h0040);
		cyc(2);
		wait_irq(60);
		rd(A_SWORD_BASE + 6'(SW_CPT), 16'h000A);
		wr(A_IRQ_MASK, 16'h0000);
		// Output policies with the host away, points 9..12 as outputs
		rcmp_on <= 8'hA5;
		wr(A_CFG, 16'h3C00);
		cyc(3);
		check({out_main, point_out, point_oe, 4'h0}, 16'h5AF0);
		wr(A_CFG, 16'h7C00);
		cyc(3);
		check({out_main, point_out, point_oe, 4'h0}, 16'h00F0);
		wr(A_HOST, 16'h0003);
		cyc(3);
		check(16'(out_main), 16'h0005);
		wr(A_CFG, 16'hBC00);
		wr(A_HOST, 16'h0000);
		rcmp_on <= 8'h3C;
		cyc(3);
		check({out_main, point_out, 8'h00}, 16'h5A00);
		wr(A_HOST, 16'h0003);
		cyc(3);
		check({out_main, point_out, 8'h00}, 16'hC300);
		// Policy code 3 behaves as continue
		wr(A_CFG, 16'hFC00);
		wr(A_HOST, 16'h0000);
		rcmp_on <= 8'h81;
		cyc(3);
		check({out_main, point_out, 8'h00}, 16'h1800);
		close_out();
	end

endmodule : encoder_io_strobe_timer_config_tb_top
